// ===== hw/dsp_channel.sv
`include "dsp_params.svh"
`default_nettype none
// one serial channel: receiver and transmitter sharing a tick enable
module dsp_channel #(
  parameter int DATA_BITS = `DSP_DATA_BITS
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 tick,
  input  wire logic                 serial_in,
  output logic                      serial_out,
  output logic                      send_request,
  input  wire logic                 send_grant,
  input  wire logic                 tx_enable,
  input  wire logic                 loopback,
  input  wire logic                 flow_enable,
  input  wire logic [DATA_BITS-1:0] tx_data,
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  output logic [DATA_BITS-1:0]      rx_data,
  output logic                      rx_valid,
  output logic                      rx_frame_err
);
  localparam int CW = $clog2(DATA_BITS + 1);
  localparam logic [3:0] MID = `DSP_MID_TICK;
  localparam logic [3:0] LAST = 4'(`DSP_OVERSAMPLE - 5'h01);

  // three-stage synchronisers on pins
  logic [2:0] rx_sync_reg;
  logic [2:0] grant_sync_reg;
  logic       rx_pin_reg;
  logic       grant_reg;
  logic       rx_line;

  dsp_pkg::dsp_tx_state_type tx_state_reg;
  dsp_pkg::dsp_rx_state_type rx_state_reg;
  logic [3:0]           tx_tick_reg;
  logic [3:0]           rx_tick_reg;
  logic [CW-1:0]        tx_bit_reg;
  logic [CW-1:0]        rx_bit_reg;
  logic [DATA_BITS-1:0] tx_shift_reg;
  logic [DATA_BITS-1:0] rx_shift_reg;
  logic                 tx_line_reg;
  logic                 tx_phase_reg;
  logic                 tx_line_next;
  logic                 tx_start;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_sync_reg    <= 3'h7;
      grant_sync_reg <= 3'h0;
      rx_pin_reg     <= 1'b1;
      grant_reg      <= 1'b0;
    end else begin
      rx_sync_reg    <= {rx_sync_reg[1:0], serial_in};
      grant_sync_reg <= {grant_sync_reg[1:0], send_grant};
      if (rx_sync_reg[1] == rx_sync_reg[2]) begin
        rx_pin_reg <= rx_sync_reg[2];
      end
      if (grant_sync_reg[1] == grant_sync_reg[2]) begin
        grant_reg <= grant_sync_reg[2];
      end
    end
  end

  // loopback feeds the receiver from the transmitter
  assign rx_line = loopback ? tx_line_reg : rx_pin_reg;

  assign send_request = tx_enable && (tx_valid ||
                        tx_state_reg != dsp_pkg::DSP_TX_IDLE);
  assign tx_start = tx_enable && tx_valid &&
                    (grant_reg || !flow_enable);
  assign tx_ready = (tx_state_reg == dsp_pkg::DSP_TX_IDLE) &&
                    tx_start && tick && !tx_phase_reg;

  // line value for the next bit
  always_comb begin
    tx_line_next = `DSP_IDLE_LEVEL;
    case (tx_state_reg)
      dsp_pkg::DSP_TX_START: tx_line_next = 1'b0;
      dsp_pkg::DSP_TX_DATA:  tx_line_next = tx_shift_reg[0];
      default:               tx_line_next = `DSP_IDLE_LEVEL;
    endcase
  end

  // transmitter: bit boundaries fall on the falling phase of the
  // serial clock; the phase flag marks rising/falling half periods
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_state_reg <= dsp_pkg::DSP_TX_IDLE;
      tx_tick_reg  <= 4'h0;
      tx_bit_reg   <= '0;
      tx_shift_reg <= '0;
      tx_phase_reg <= 1'b0;
    end else if (tick) begin
      tx_phase_reg <= ~tx_phase_reg;
      case (tx_state_reg)
        dsp_pkg::DSP_TX_IDLE: begin
          if (tx_ready) begin
            tx_shift_reg <= tx_data;
            tx_tick_reg  <= 4'h0;
            tx_state_reg <= dsp_pkg::DSP_TX_START;
          end
        end
        dsp_pkg::DSP_TX_START: begin
          tx_tick_reg <= tx_tick_reg + 4'h1;
          if (tx_tick_reg == LAST) begin
            tx_bit_reg   <= '0;
            tx_state_reg <= dsp_pkg::DSP_TX_DATA;
          end
        end
        dsp_pkg::DSP_TX_DATA: begin
          tx_tick_reg <= tx_tick_reg + 4'h1;
          if (tx_tick_reg == LAST) begin
            tx_shift_reg <= tx_shift_reg >> 1;
            tx_bit_reg   <= tx_bit_reg + CW'(1);
            if (tx_bit_reg == CW'(DATA_BITS - 1)) begin
              tx_state_reg <= dsp_pkg::DSP_TX_STOP;
            end
          end
        end
        dsp_pkg::DSP_TX_STOP: begin
          tx_tick_reg <= tx_tick_reg + 4'h1;
          if (tx_tick_reg == LAST) begin
            tx_state_reg <= dsp_pkg::DSP_TX_IDLE;
          end
        end
        default: tx_state_reg <= dsp_pkg::DSP_TX_IDLE;
      endcase
    end
  end

  // output changes on falling phase only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_line_reg <= `DSP_IDLE_LEVEL;
    end else if (tick && tx_phase_reg) begin
      tx_line_reg <= tx_enable ? tx_line_next : `DSP_IDLE_LEVEL;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serial_out <= `DSP_IDLE_LEVEL;
    end else begin
      serial_out <= loopback ? `DSP_IDLE_LEVEL : tx_line_reg;
    end
  end

  // receiver: samples mid-bit on the rising phase tick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_state_reg <= dsp_pkg::DSP_RX_IDLE;
      rx_tick_reg  <= 4'h0;
      rx_bit_reg   <= '0;
      rx_shift_reg <= '0;
      rx_data      <= '0;
      rx_valid     <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rx_valid     <= 1'b0;
      rx_frame_err <= 1'b0;
      if (tick) begin
        case (rx_state_reg)
          dsp_pkg::DSP_RX_IDLE: begin
            // start on a rising-phase tick, so every later sample
            // lands on one too; costs up to one tick of sample skew
            if (!rx_line && !tx_phase_reg) begin
              rx_tick_reg  <= 4'h0;
              rx_state_reg <= dsp_pkg::DSP_RX_START;
            end
          end
          dsp_pkg::DSP_RX_START: begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == MID) begin
              if (rx_line) begin
                rx_state_reg <= dsp_pkg::DSP_RX_IDLE;
              end else begin
                rx_tick_reg  <= 4'h0;
                rx_bit_reg   <= '0;
                rx_state_reg <= dsp_pkg::DSP_RX_DATA;
              end
            end
          end
          dsp_pkg::DSP_RX_DATA: begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == LAST) begin
              rx_shift_reg <= {rx_line, rx_shift_reg[DATA_BITS-1:1]};
              rx_bit_reg   <= rx_bit_reg + CW'(1);
              if (rx_bit_reg == CW'(DATA_BITS - 1)) begin
                rx_state_reg <= dsp_pkg::DSP_RX_STOP;
              end
            end
          end
          dsp_pkg::DSP_RX_STOP: begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == LAST) begin
              rx_data      <= rx_shift_reg;
              rx_valid     <= rx_line;
              rx_frame_err <= !rx_line;
              rx_state_reg <= dsp_pkg::DSP_RX_IDLE;
            end
          end
          default: rx_state_reg <= dsp_pkg::DSP_RX_IDLE;
        endcase
      end
    end
  end
endmodule : dsp_channel
`default_nettype wire

// ===== hw/dsp_params.svh
`ifndef DSP_PARAMS_SVH
`define DSP_PARAMS_SVH
// data bits per character
`define DSP_DATA_BITS      8
// serial clock tick period in system clocks (oversample x16 base)
`define DSP_TICK_DIV       16'h0036
// ticks per bit
`define DSP_OVERSAMPLE     5'h10
// middle of a bit, in ticks
`define DSP_MID_TICK       4'h7
// stop bits sent
`define DSP_STOP_BITS      2'h1
// idle line level
`define DSP_IDLE_LEVEL     1'b1
`endif

// ===== hw/dsp_pkg.sv
`default_nettype none
package dsp_pkg;
  typedef enum logic [1:0] {
    DSP_TX_IDLE  = 2'h0,
    DSP_TX_START = 2'h1,
    DSP_TX_DATA  = 2'h3,
    DSP_TX_STOP  = 2'h2
  } dsp_tx_state_type;
  typedef enum logic [1:0] {
    DSP_RX_IDLE  = 2'h0,
    DSP_RX_START = 2'h1,
    DSP_RX_DATA  = 2'h3,
    DSP_RX_STOP  = 2'h2
  } dsp_rx_state_type;
endpackage : dsp_pkg
`default_nettype wire

// ===== hw/dsp_dual_serial_port.sv
`include "dsp_params.svh"
`default_nettype none
module dsp_dual_serial_port #(
  parameter int          DATA_BITS = `DSP_DATA_BITS,
  parameter logic [15:0] TICK_DIV  = `DSP_TICK_DIV
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 serial_in_ch0,
  input  wire logic                 serial_in_ch1,
  output logic                      serial_out_ch0,
  output logic                      serial_out_ch1,
  output logic                      send_request_ch0,
  output logic                      send_request_ch1,
  input  wire logic                 send_grant_ch0,
  input  wire logic                 send_grant_ch1,
  input  wire logic [1:0]           tx_enable,
  input  wire logic [1:0]           loopback,
  input  wire logic [1:0]           flow_enable,
  input  wire logic [DATA_BITS-1:0] tx_data_ch0,
  input  wire logic [DATA_BITS-1:0] tx_data_ch1,
  input  wire logic [1:0]           tx_valid,
  output logic [1:0]                tx_ready,
  output logic [DATA_BITS-1:0]      rx_data_ch0,
  output logic [DATA_BITS-1:0]      rx_data_ch1,
  output logic [1:0]                rx_valid,
  output logic [1:0]                rx_frame_err
);
  logic [15:0] div_reg;
  logic        tick;

  // one shared serial clock source; each tick is one sixteenth of a bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 16'h0000;
    end else if (div_reg == TICK_DIV - 16'h0001) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end
  assign tick = (div_reg == TICK_DIV - 16'h0001);

  // per-channel pins gathered into vectors so one loop serves both
  logic [1:0]           serial_in_w;
  logic [1:0]           serial_out_w;
  logic [1:0]           send_request_w;
  logic [1:0]           send_grant_w;
  logic [DATA_BITS-1:0] tx_data_w [2];
  logic [DATA_BITS-1:0] rx_data_w [2];

  assign serial_in_w      = {serial_in_ch1, serial_in_ch0};
  assign send_grant_w     = {send_grant_ch1, send_grant_ch0};
  assign tx_data_w[0]     = tx_data_ch0;
  assign tx_data_w[1]     = tx_data_ch1;
  assign serial_out_ch0   = serial_out_w[0];
  assign serial_out_ch1   = serial_out_w[1];
  assign send_request_ch0 = send_request_w[0];
  assign send_request_ch1 = send_request_w[1];
  assign rx_data_ch0      = rx_data_w[0];
  assign rx_data_ch1      = rx_data_w[1];

  // one channel each, sharing nothing but the tick
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    dsp_channel #(.DATA_BITS(DATA_BITS)) u_chan (
      .clk          (clk),
      .rstn         (rstn),
      .tick         (tick),
      .serial_in    (serial_in_w[ch]),
      .serial_out   (serial_out_w[ch]),
      .send_request (send_request_w[ch]),
      .send_grant   (send_grant_w[ch]),
      .tx_enable    (tx_enable[ch]),
      .loopback     (loopback[ch]),
      .flow_enable  (flow_enable[ch]),
      .tx_data      (tx_data_w[ch]),
      .tx_valid     (tx_valid[ch]),
      .tx_ready     (tx_ready[ch]),
      .rx_data      (rx_data_w[ch]),
      .rx_valid     (rx_valid[ch]),
      .rx_frame_err (rx_frame_err[ch])
    );
  end
endmodule : dsp_dual_serial_port
`default_nettype wire

// ===== sim/dsp_dual_serial_port_asserts.sv
`default_nettype none
module dsp_dual_serial_port_asserts #(
  parameter logic [15:0] TICK_DIV = 16'h0036
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       serial_out_ch0,
  input  wire logic       serial_out_ch1,
  input  wire logic       send_request_ch0,
  input  wire logic       send_request_ch1,
  input  wire logic       send_grant_ch0,
  input  wire logic [1:0] tx_enable,
  input  wire logic [1:0] loopback,
  input  wire logic [1:0] flow_enable,
  input  wire logic [1:0] tx_valid,
  input  wire logic [1:0] tx_ready,
  input  wire logic [1:0] rx_valid,
  input  wire logic [1:0] rx_frame_err
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  localparam int BIT_CLKS = 16 * int'(TICK_DIV);
  // accept tick, one tick to the falling phase, then two register stages
  localparam int START_LAG = int'(TICK_DIV) + 2;
  int low_run;
  // a low stretch must end on a bit boundary
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_run <= 0;
    end else if (serial_out_ch0) begin
      low_run <= 0;
    end else begin
      low_run <= low_run + 1;
    end
  end
  chk_bit_length: assert property (
    $rose(serial_out_ch0) |-> (low_run % BIT_CLKS) == 0)
    else $error("low run not whole bits");
  chk_start_soon: assert property (
    tx_ready[0] && !loopback[0] |-> ##[1:START_LAG] !serial_out_ch0)
    else $error("no start bit after accept");
  chk_ready_grant: assert property (
    tx_ready[0] && flow_enable[0] |-> $past(send_grant_ch0, 3))
    else $error("accept without grant");
  chk_ready_cause: assert property (
    tx_ready[1] |-> tx_valid[1] && tx_enable[1])
    else $error("accept without request");
  chk_rts_on: assert property (
    tx_enable[0] && tx_valid[0] |-> send_request_ch0)
    else $error("request to send missing");
  chk_rts_off: assert property (
    !tx_enable[1] |-> !send_request_ch1)
    else $error("request to send while disabled");
  chk_dis_high: assert property (
    !tx_enable[1] && !$past(tx_enable[1], 8) |-> serial_out_ch1)
    else $error("disabled line not high");
  chk_loop_high: assert property (
    loopback[1] && $past(loopback[1], 8) |-> serial_out_ch1)
    else $error("loopback pin not high");
  chk_rx_pulse: assert property (
    rx_valid[0] |=> !rx_valid[0] && !rx_frame_err[0])
    else $error("receive flag longer than a pulse");
endmodule : dsp_dual_serial_port_asserts
bind dsp_dual_serial_port dsp_dual_serial_port_asserts #(
  .TICK_DIV(TICK_DIV)
) u_chk (.clk, .rstn, .serial_out_ch0, .serial_out_ch1,
  .send_request_ch0, .send_request_ch1, .send_grant_ch0, .tx_enable,
  .loopback, .flow_enable, .tx_valid, .tx_ready, .rx_valid,
  .rx_frame_err);
`default_nettype wire

// ===== sim/dsp_peer.sv
`default_nettype none
module dsp_peer #(
  parameter int BIT = 32
) (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out,
  output logic      grant,
  input  wire logic grant_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_byte;
  int         got_n;
  assign grant = grant_on;
  initial begin
    line_out = 1'b1;
    got_byte = 8'h00;
    got_n = 0;
  end
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      got_byte[i] = line_in;
    end
    repeat (BIT) @(posedge clk);
    got_n++;
  end
  // start, data lsb first, stop level chosen by caller
  task automatic send(input logic [7:0] d, input logic stop);
    line_out <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      line_out <= d[i];
      repeat (BIT) @(posedge clk);
    end
    line_out <= stop;
    repeat (BIT) @(posedge clk);
    line_out <= 1'b1;
  endtask : send
endmodule : dsp_peer
`default_nettype wire

// ===== sim/dsp_dual_serial_port_tb.sv
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module dsp_dual_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 32;
  logic       clk = 1'b0, rstn = 1'b0;
  logic       serial_in_ch0, serial_in_ch1, serial_out_ch0, serial_out_ch1;
  logic       send_request_ch0, send_request_ch1;
  logic       send_grant_ch0, send_grant_ch1;
  logic [1:0] tx_enable = 2'h0, loopback = 2'h0, flow_enable = 2'h0;
  logic [1:0] tx_valid = 2'h0, grant_on = 2'h3;
  logic [1:0] tx_ready, rx_valid, rx_frame_err;
  logic [7:0] tx_data_ch0 = 8'h00, tx_data_ch1 = 8'h00;
  logic [7:0] rx_data_ch0, rx_data_ch1, rx_last0, rx_last1, b0, b1;
  int         bad_count = 0, n_compared = 0, ferr0 = 0, ferr1 = 0, n0, seed;
  always #5 clk = ~clk;
  dsp_dual_serial_port #(.DATA_BITS(8), .TICK_DIV(16'h0002)) dut (.*);
  dsp_peer #(.BIT(BIT)) p0 (.clk(clk), .line_in(serial_out_ch0),
    .line_out(serial_in_ch0), .grant(send_grant_ch0), .grant_on(grant_on[0]));
  dsp_peer #(.BIT(BIT)) p1 (.clk(clk), .line_in(serial_out_ch1),
    .line_out(serial_in_ch1), .grant(send_grant_ch1), .grant_on(grant_on[1]));
  always @(posedge clk) begin
    if (rx_valid[0] === 1'b1)
      rx_last0 <= rx_data_ch0;
    if (rx_valid[1] === 1'b1)
      rx_last1 <= rx_data_ch1;
    if (rx_frame_err[0] === 1'b1)
      ferr0++;
    if (rx_frame_err[1] === 1'b1)
      ferr1++;
  end
  // corner bytes first, then random ones
  function automatic logic [7:0] pick(input int i);
    logic [7:0] corner [4] = '{8'h00, 8'hFF, 8'h01, 8'h80};
    return (i < 4) ? corner[i] : 8'($random(seed));
  endfunction : pick
  task automatic xmit(input int c, input logic [7:0] d);
    int k;
    k = 0;
    if (c == 0)
      tx_data_ch0 <= d;
    else
      tx_data_ch1 <= d;
    tx_valid[c] <= 1'b1;
    do begin
      @(negedge clk);
      k++;
    end while (tx_ready[c] !== 1'b1 && k < 3000);
    @(posedge clk);
    tx_valid[c] <= 1'b0;
    `CHK(k < 3000, 1'b1)
  endtask : xmit
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    seed = 32'hA51AE5D5;
    repeat (6) @(posedge clk);
    `CHK(serial_out_ch0, 1'b1)
    `CHK(send_request_ch1, 1'b0)
    rstn <= 1'b1;
    tx_enable <= 2'h3;
    for (int i = 0; i < 12; i++) begin
      b0 = pick(i);
      b1 = pick(i + 5);
      fork
        xmit(0, b0);
        xmit(1, b1);
        p0.send(b1, 1'b1);
        p1.send(b0, 1'b1);
      join
      repeat (3 * BIT) @(posedge clk);
      `CHK(p0.got_byte, b0)
      `CHK(p1.got_byte, b1)
      `CHK(rx_last0, b1)
      `CHK(rx_last1, b0)
    end
    grant_on[0] <= 1'b0;
    repeat (10) @(posedge clk);
    flow_enable <= 2'h1;
    n0 = p0.got_n;
    fork
      xmit(0, 8'hA5);
    join_none
    repeat (300) @(posedge clk);
    `CHK(send_request_ch0, 1'b1)
    `CHK(p0.got_n, n0)
    grant_on[0] <= 1'b1;
    repeat (12 * BIT) @(posedge clk);
    `CHK(p0.got_byte, 8'hA5)
    // disable in the middle of an all-zero character: the rest goes high
    xmit(1, 8'h00);
    repeat (2 * BIT) @(posedge clk);
    `CHK(serial_out_ch1, 1'b0)
    tx_enable[1] <= 1'b0;
    tx_valid[1] <= 1'b1;
    repeat (12 * BIT) @(posedge clk);
    `CHK(p1.got_byte, 8'hFE)
    `CHK(serial_out_ch1, 1'b1)
    `CHK(send_request_ch1, 1'b0)
    tx_valid[1] <= 1'b0;
    tx_enable[1] <= 1'b1;
    loopback <= 2'h2;
    n0 = p1.got_n;
    repeat (10) @(posedge clk);
    xmit(1, 8'h3C);
    repeat (12 * BIT) @(posedge clk);
    `CHK(rx_last1, 8'h3C)
    `CHK(p1.got_n, n0)
    p0.send(8'h5A, 1'b0);
    repeat (2 * BIT) @(posedge clk);
    `CHK(ferr0, 1)
    `CHK(ferr1, 0)
    report_and_stop();
  end
endmodule : dsp_dual_serial_port_tb
`default_nettype wire
